// *** pkg/lin_break_sync_regs.svh ***
// timing counts and field constants for the break/synch detector
// assumes inclusion by bare name from the package and design files
`ifndef LIN_BREAK_SYNC_REGS_SVH
`define LIN_BREAK_SYNC_REGS_SVH
`define BRK_CNT_MAX 12'hfff
`define BRK_THRESHOLD_BITS 11
`define SAMPLE_BASE_DIV 8
`define SYNCH_BYTE_VALUE 8'h55
`define SYNCH_LAST_EDGE 5
`define RANGE_SEL_RESET 2'h0
`define RATE_MIN_DIV 2184
`define RATE_MAX_DIV 72
`endif

// *** pkg/lin_break_sync_pkg.sv ***
// types shared by the break/synch detector and its sample divider
// assumes the _regs header is on the include path
`include "lin_break_sync_regs.svh"
package lin_break_sync_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_BREAK = 5'b00010,
    ST_DELIM = 5'b00100,
    ST_SYNCH = 5'b01000,
    ST_DONE  = 5'b10000
  } detect_state_e;
  typedef logic [11:0] brk_count_t;
endpackage

// *** rtl/sample_tick_gen.sv ***
// sample tick generator: clk divided by 8 * 2^range
// assumes range select is stable while detection is enabled
`include "lin_break_sync_regs.svh"
module sample_tick_gen
  import lin_break_sync_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic [1:0] rate_range_select_i,
  // tick out
  output logic tick_o
);
  logic [6:0] div_reg;
  logic [6:0] limit;

  // ------------------------------------------------------------
  // divider
  // ------------------------------------------------------------
  always_comb begin
    // range r slows sampling by 2^r, widening the span [RULE13]
    limit = 7'((`SAMPLE_BASE_DIV << rate_range_select_i) - 1); // [RULE12]
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_reg <= 7'h00;
    end else if (!run_i || div_reg == limit) begin
      div_reg <= 7'h00;
    end else begin
      div_reg <= div_reg + 7'h01;
    end
  end

  assign tick_o = run_i && (div_reg == limit);

endmodule // sample_tick_gen

// *** rtl/lin_break_sync_baud_detect.sv ***
// lin break and synch-field detector with capture timer control
// assumes rx_i is synchronous to clk_i; software clears flags by pulses
// What the document requires
// RULE1: a responding slave sends 2, 4 or 8 data bytes then a checksum
// RULE2: header sending is allowed only in master mode
// RULE3: header is break, then synch byte, then identifier field
// RULE4: master holds the bus dominant at least thirteen bit times
// RULE5: break is not an ordinary byte; master drives it separately
// RULE6: software picks 8-bit variable mode and the rate range first
// RULE7: writing enable to zero then one reinitialises the detector
// RULE8: software clears break, synch-end and synch-error flags at init
// RULE9: software sets timer to falling-edge capture, edge 0, capture 1
// RULE10: with event enable set, every falling edge sets the event flag
// RULE11: break counter saturates at 4095 and then flags an error
// RULE12: sample rate is input clock over eight times two to range
// RULE13: range r detects clock/(2184*2^r) up to clock/(72*2^r)
// RULE14: software should prefer range zero when several ranges fit
// RULE15: first falling edge sets the timer external start enable
// RULE16: second falling edge starts the capture timer in hardware
// RULE17: third falling edge captures the two-bit duration
// RULE18: software may then extend capture to four, six or eight bits
// RULE19: at synch end set synch-end flag and stop the timer
// RULE20: software computes rate and loads prescale and reload values
// RULE21: software drops the frame if no break or synch error
// RULE22: software resynchronises for every header
// RULE23: dominant time of eleven bit times counts as a valid break
// RULE24: synch byte is 55 hex, lsb first, start low, stop high
// RULE25: synch flags are set by hardware, cleared only by software
// RULE26: uneven two-bit edge intervals set the synch-error flag
// RULE27: break low time is counted on sample ticks while enabled
`include "lin_break_sync_regs.svh"
module lin_break_sync_baud_detect
  import lin_break_sync_pkg::*;
#(
  parameter int TIMER_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus receive line and mode
  input wire logic rx_i,
  input wire logic master_mode_i,
  input wire logic header_req_i,
  // configuration
  input wire logic break_detect_enable_i,
  input wire logic [1:0] rate_range_select_i,
  input wire logic timer_ext_event_enable_i,
  input wire logic timer_start_edge_select_i,
  input wire logic [1:0] synch_bits_select_i,
  // flag clears, one-cycle pulses
  input wire logic break_detected_clr_i,
  input wire logic synch_end_clr_i,
  input wire logic synch_error_clr_i,
  input wire logic timer_ext_event_clr_i,
  // status
  output logic break_detected_flag_o,
  output logic synch_end_flag_o,
  output logic synch_error_flag_o,
  output logic timer_ext_event_flag_o,
  output logic timer_ext_start_enable_o,
  output logic timer_run_o,
  output logic [TIMER_W-1:0] timer_capture_value_o,
  output logic capture_valid_o,
  output logic header_break_en_o
);
  detect_state_e state_reg, state_next;
  logic rx_prev_reg;
  logic en_prev_reg;
  logic fall;
  logic reinit;
  logic tick;
  brk_count_t brk_cnt_reg;
  logic [23:0] brk_clocks;
  logic [23:0] brk_limit;
  logic [2:0] edge_cnt_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic [TIMER_W-1:0] last_mark_reg;
  logic [TIMER_W-1:0] interval;
  logic [TIMER_W-1:0] first_int_reg;
  logic [2:0] edges_needed;
  logic brk_ovf;
  logic brk_ok;
  logic set_brk, set_end, set_err;

  // ------------------------------------------------------------
  // edge and enable detection
  // ------------------------------------------------------------
  function automatic logic close_enough(input logic [TIMER_W-1:0] a,
                                        input logic [TIMER_W-1:0] b);
    logic [TIMER_W-1:0] d;
    d = (a > b) ? a - b : b - a;
    // quarter-interval tolerance absorbs sampling jitter
    close_enough = (d <= (b >> 2));
  endfunction

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_prev_reg <= 1'b1;
      en_prev_reg <= 1'b0;
    end else begin
      rx_prev_reg <= rx_i;
      en_prev_reg <= break_detect_enable_i;
    end
  end

  assign fall = rx_prev_reg && !rx_i;
  assign reinit = break_detect_enable_i && !en_prev_reg; // [RULE7]

  sample_tick_gen sample_tick_gen_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(break_detect_enable_i),
    .rate_range_select_i(rate_range_select_i),
    .tick_o(tick)
  );

  // ------------------------------------------------------------
  // header sequencing
  // ------------------------------------------------------------
  // 2/4/6/8 bits of synch need 2..5 falling edges after the break
  assign edges_needed = 3'(synch_bits_select_i) + 3'h1; // [RULE18]
  assign brk_ovf = (brk_cnt_reg == `BRK_CNT_MAX);
  assign interval = timer_reg - last_mark_reg; // [RULE24]
  // valid break: low for 11 bit times, bit time from synch 2-bit span
  assign brk_clocks = (24'(brk_cnt_reg) * 24'(`SAMPLE_BASE_DIV))
                      << rate_range_select_i;
  assign brk_limit = 24'(interval >> 1) * 24'(`BRK_THRESHOLD_BITS);
  assign brk_ok = !brk_ovf && (brk_clocks >= brk_limit); // [RULE23]

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  if (fall) state_next = ST_BREAK; // [RULE15]
      ST_BREAK: begin
        if (brk_ovf) state_next = ST_DONE; // [RULE11]
        else if (rx_i) state_next = ST_DELIM;
      end
      ST_DELIM: if (fall) state_next = ST_SYNCH; // [RULE3] [RULE16]
      ST_SYNCH: begin
        if (set_err) state_next = ST_DONE;
        else if (fall && edge_cnt_reg + 3'h1 == edges_needed)
          state_next = ST_DONE; // [RULE19]
      end
      ST_DONE:  state_next = ST_DONE;
      default:  state_next = ST_IDLE;
    endcase
    if (!break_detect_enable_i || reinit) state_next = ST_IDLE;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  // break length counted in sample ticks, saturating
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      brk_cnt_reg <= '0;
    end else if (state_reg == ST_IDLE) begin
      brk_cnt_reg <= '0;
    end else if (state_reg == ST_BREAK && tick && !brk_ovf) begin
      brk_cnt_reg <= brk_cnt_reg + 12'h001; // [RULE27] [RULE11]
    end
  end

  // ------------------------------------------------------------
  // capture timer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_reg <= '0;
    end else if (state_reg == ST_DELIM) begin
      timer_reg <= '0;
    end else if (state_reg == ST_SYNCH) begin
      timer_reg <= timer_reg + TIMER_W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      edge_cnt_reg <= 3'h0;
      last_mark_reg <= '0;
      first_int_reg <= '0;
    end else if (state_reg == ST_DELIM) begin
      edge_cnt_reg <= 3'h0;
      last_mark_reg <= '0;
    end else if (state_reg == ST_SYNCH && fall) begin
      edge_cnt_reg <= edge_cnt_reg + 3'h1;
      last_mark_reg <= timer_reg;
      if (edge_cnt_reg == 3'h0) begin
        first_int_reg <= interval;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_capture_value_o <= '0;
      capture_valid_o <= 1'b0;
    end else if (reinit) begin
      capture_valid_o <= 1'b0;
    end else if (state_reg == ST_SYNCH && fall) begin
      timer_capture_value_o <= timer_reg; // [RULE17]
      capture_valid_o <= 1'b1;
    end
  end

  assign timer_run_o = (state_reg == ST_SYNCH); // [RULE16] [RULE19]

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_ext_start_enable_o <= 1'b0;
    end else if (state_reg == ST_IDLE && fall && break_detect_enable_i &&
                 !timer_start_edge_select_i) begin
      timer_ext_start_enable_o <= 1'b1; // [RULE15]
    end else if (state_reg == ST_IDLE || state_reg == ST_DONE) begin
      timer_ext_start_enable_o <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // flags: set wins over software clear
  // ------------------------------------------------------------
  // break valid when low time (ticks*sample) reaches at least 11 bit times
  assign set_brk = state_reg == ST_SYNCH && fall && edge_cnt_reg == 3'h0 &&
                   brk_ok && (brk_cnt_reg != 12'h000); // [RULE23]
  assign set_err = (state_reg == ST_BREAK && brk_ovf) || // [RULE11]
                   (state_reg == ST_SYNCH && fall && edge_cnt_reg != 3'h0 &&
                    !close_enough(interval, first_int_reg)); // [RULE26]
  assign set_end = state_reg == ST_SYNCH && fall && !set_err &&
                   edge_cnt_reg + 3'h1 == edges_needed; // [RULE19]

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      break_detected_flag_o <= 1'b0;
      synch_end_flag_o <= 1'b0;
      synch_error_flag_o <= 1'b0;
    end else begin
      // [RULE25]
      if (set_brk) break_detected_flag_o <= 1'b1;
      else if (break_detected_clr_i) break_detected_flag_o <= 1'b0;
      if (set_end) synch_end_flag_o <= 1'b1;
      else if (synch_end_clr_i) synch_end_flag_o <= 1'b0;
      if (set_err) synch_error_flag_o <= 1'b1;
      else if (synch_error_clr_i) synch_error_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_ext_event_flag_o <= 1'b0;
    end else if (timer_ext_event_enable_i && fall) begin
      timer_ext_event_flag_o <= 1'b1; // [RULE10]
    end else if (timer_ext_event_clr_i) begin
      timer_ext_event_flag_o <= 1'b0;
    end
  end

  // break drive comes from a dedicated master path, not a byte
  assign header_break_en_o = master_mode_i && header_req_i; // [RULE2] [RULE5]

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_first_synch_edge;
    state_reg == ST_SYNCH && fall && edge_cnt_reg == 3'h0;
  endsequence

  property p_ext_event;
    @(posedge clk_i) disable iff (rst_i)
      timer_ext_event_enable_i && fall |=> timer_ext_event_flag_o;
  endproperty
  a_ext_event: assert property (p_ext_event) // [RULE10]
    else $error("event flag not set on falling edge");

  property p_capture;
    @(posedge clk_i) disable iff (rst_i)
      s_first_synch_edge |=> timer_capture_value_o == $past(timer_reg);
  endproperty
  a_capture: assert property (p_capture) // [RULE17]
    else $error("capture value wrong at third edge");

  property p_end_stops;
    @(posedge clk_i) disable iff (rst_i)
      set_end && break_detect_enable_i |=> synch_end_flag_o && !timer_run_o;
  endproperty
  a_end_stops: assert property (p_end_stops) // [RULE19]
    else $error("synch end did not stop timer");

  property p_sat;
    @(posedge clk_i) disable iff (rst_i)
      brk_cnt_reg == `BRK_CNT_MAX && state_reg == ST_BREAK
      |=> synch_error_flag_o;
  endproperty
  a_sat: assert property (p_sat) // [RULE11]
    else $error("overflow not flagged");

  property p_flag_sticky;
    @(posedge clk_i) disable iff (rst_i)
      synch_error_flag_o && !synch_error_clr_i |=> synch_error_flag_o;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // [RULE25]
    else $error("error flag dropped without clear");

  property p_reinit;
    @(posedge clk_i) disable iff (rst_i)
      reinit |=> state_reg == ST_IDLE && !timer_run_o;
  endproperty
  a_reinit: assert property (p_reinit) // [RULE7]
    else $error("reenable did not reset detector");

  property p_start;
    @(posedge clk_i) disable iff (rst_i)
      state_reg == ST_DELIM && fall && break_detect_enable_i
      |=> timer_run_o ##1 timer_reg == TIMER_W'(1);
  endproperty
  a_start: assert property (p_start) // [RULE16]
    else $error("timer not started on second edge");

  property p_hdr;
    @(posedge clk_i) disable iff (rst_i)
      header_break_en_o |-> master_mode_i;
  endproperty
  a_hdr: assert property (p_hdr) // [RULE2]
    else $error("header outside master mode");

  property p_rse;
    @(posedge clk_i) disable iff (rst_i)
      state_reg == ST_IDLE && fall && !timer_start_edge_select_i &&
      break_detect_enable_i |=> timer_ext_start_enable_o;
  endproperty
  a_rse: assert property (p_rse) // [RULE15]
    else $error("start enable not set on first edge");

endmodule // lin_break_sync_baud_detect

// *** sim/lin_master_model.sv ***
// lin master model: drives break, delimiter, synch byte and id on rx
// assumes one clock; a header is launched by a one-cycle send_i
module lin_master_model (
  // clock
  input wire logic clk_i,
  // header control
  input wire logic send_i,
  input wire logic [15:0] bit_cyc_i,
  input wire logic [15:0] brk_bits_i,
  input wire logic [7:0] synch_i,
  input wire logic [3:0] resp_i,
  // bus side
  output logic rx_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------
  // line drive helpers
  // --------------------------------------------------
  task automatic hold(input logic v, input int n);
    rx_o <= v;
    repeat (n * int'(bit_cyc_i)) @(posedge clk_i);
  endtask

  task automatic send_byte(input logic [7:0] b);
    hold(1'b0, 1); // dominant start, lsb first, recessive stop
    for (int i = 0; i < 8; i++) begin
      hold(b[i], 1);
    end
    hold(1'b1, 1);
  endtask

  // --------------------------------------------------
  // header sequencer
  // --------------------------------------------------
  // idle line is recessive, as the bus pull-up leaves it
  initial begin
    rx_o = 1'b1;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (send_i) begin
        busy_o <= 1'b1;
        hold(1'b0, int'(brk_bits_i)); // one long low
        hold(1'b1, 1);
        send_byte(synch_i); // break, synch, then id
        send_byte(8'h3c);
        for (int k = 0; k < int'(resp_i); k++) begin
          send_byte(8'ha0 + 8'(k)); // resp_i data bytes, 0 to 15
        end
        if (resp_i != 4'h0) begin
          send_byte(8'h5f); // check byte closes the response
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule // lin_master_model

// *** sim/test_lin_break_sync_baud_detect.sv ***
// self-checking bench for the break/synch detector
// assumes the lin master model drives rx; clock 50 MHz
module test_lin_break_sync_baud_detect;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 76;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rx, master, hreq, en, evt_en, send, busy, edge_sel;
  logic [3:0] resp;
  logic brk_clr, end_clr, err_clr, evt_clr;
  logic brk_f, end_f, err_f, evt_f, start_en, run, cap_ok, hdr_en;
  logic [1:0] range, sbits;
  logic [15:0] cap, brk_bits;
  logic [7:0] synch;
  int n_fail = 0;
  int samples_checked = 0;

  always #10 clk_i = ~clk_i;

  lin_break_sync_baud_detect lin_break_sync_baud_detect_inst (
    .clk_i(clk_i), .rst_i(rst_i), .rx_i(rx), .master_mode_i(master),
    .header_req_i(hreq), .break_detect_enable_i(en),
    .rate_range_select_i(range), .timer_ext_event_enable_i(evt_en),
    .timer_start_edge_select_i(edge_sel), .synch_bits_select_i(sbits),
    .break_detected_clr_i(brk_clr), .synch_end_clr_i(end_clr),
    .synch_error_clr_i(err_clr), .timer_ext_event_clr_i(evt_clr),
    .break_detected_flag_o(brk_f), .synch_end_flag_o(end_f),
    .synch_error_flag_o(err_f), .timer_ext_event_flag_o(evt_f),
    .timer_ext_start_enable_o(start_en), .timer_run_o(run),
    .timer_capture_value_o(cap), .capture_valid_o(cap_ok),
    .header_break_en_o(hdr_en));

  lin_master_model lin_master_model_inst (
    .clk_i(clk_i), .send_i(send), .bit_cyc_i(16'(BIT)),
    .brk_bits_i(brk_bits), .synch_i(synch), .resp_i(resp), .rx_o(rx),
    .busy_o(busy));

  // --------------------------------------------------
  // access tasks
  // --------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // edge detection latency may shift the count by a cycle or two
  task automatic chk_cap(input int bits);
    samples_checked++;
    if ($isunknown(cap) || int'(cap) < bits * BIT - 2 ||
        int'(cap) > bits * BIT + 2) begin
      n_fail++;
      $display("BAD %0t capture %h for %0d bits", $time, cap, bits);
    end
  endtask

  task automatic flags(input logic [2:0] e);
    chk({13'h0000, brk_f, end_f, err_f}, {13'h0000, e});
  endtask

  // enable low then high restarts detection; all flags cleared
  task automatic reinit(input logic [1:0] r, input logic [1:0] s);
    en = 1'b0;
    range = r;
    sbits = s;
    {brk_clr, end_clr, err_clr, evt_clr} = 4'hf;
    tick(1);
    {brk_clr, end_clr, err_clr, evt_clr} = 4'h0;
    en = 1'b1;
    tick(1);
  endtask

  task automatic header(input logic [15:0] b, input logic [7:0] y,
                        input logic st);
    brk_bits = b;
    synch = y;
    send = 1'b1;
    tick(1);
    send = 1'b0;
    for (int i = 0; i < 40000 && busy; i++) begin
      if (i == 20) chk({15'h0000, start_en}, {15'h0000, st});
      tick(1);
    end
    if (busy) begin
      n_fail++;
      $display("BAD %0t header did not finish", $time);
    end
    tick(4);
  endtask

  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // --------------------------------------------------
  // test sequence
  // --------------------------------------------------
  initial begin
    {master, hreq, en, evt_en, send, edge_sel} = 6'h00;
    {brk_clr, end_clr, err_clr, evt_clr} = 4'h0;
    {range, sbits, brk_bits, synch, resp} = 32'h00000000;
    repeat (2) @(posedge clk_i);
    #2;
    rst_i = 1'b0;
    tick(1);
    chk({9'h000, brk_f, end_f, err_f, evt_f, start_en, run, cap_ok},
        16'h0000);
    {master, hreq} = 2'h3;
    tick(1);
    chk({15'h0000, hdr_en}, 16'h0001);
    master = 1'b0;
    tick(1);
    chk({15'h0000, hdr_en}, 16'h0000);
    evt_en = 1'b1;
    for (int s = 0; s < 4; s++) begin
      reinit(2'h0, 2'(s));
      header(16'h000d, 8'h55, 1'b1);
      flags(3'b110);
      chk({14'h0000, start_en, run}, 16'h0000);
      chk({14'h0000, evt_f, cap_ok}, 16'h0003);
      chk_cap(2 * (s + 1));
      tick(20);
      flags(3'b110);
      {end_clr, evt_clr} = 2'h3;
      tick(1);
      {end_clr, evt_clr} = 2'h0;
      tick(1);
      flags(3'b100);
      chk({15'h0000, evt_f}, 16'h0000);
    end
    // a finished detector ignores a new header and reply until re-enabled
    resp = 4'h2;
    header(16'h000d, 8'h55, 1'b0);
    resp = 4'h0;
    flags(3'b100);
    reinit(2'h3, 2'h3);
    reinit(2'h0, 2'h3);
    header(16'h000d, 8'h15, 1'b1);
    chk({15'h0000, err_f}, 16'h0001);
    reinit(2'h0, 2'h0);
    header(16'd440, 8'h55, 1'b1);
    chk({14'h0000, end_f, err_f}, 16'h0001);
    reinit(2'h1, 2'h0);
    header(16'd440, 8'h55, 1'b1);
    flags(3'b110);
    chk_cap(2);
    // a short low is no break; rising-edge start leaves the enable low
    reinit(2'h0, 2'h0);
    edge_sel = 1'b1;
    header(16'h0005, 8'h55, 1'b0);
    edge_sel = 1'b0;
    flags(3'b010);
    chk_cap(2);
    reinit(2'h0, 2'h0);
    en = 1'b0;
    evt_en = 1'b0;
    header(16'h000d, 8'h55, 1'b0);
    flags(3'b000);
    chk({15'h0000, evt_f}, 16'h0000);
    end_sim();
  end

  // guard against a hang; the tests need about 93000 cycles
  initial begin
    repeat (99000) @(posedge clk_i);
    n_fail++;
    end_sim();
  end
endmodule // test_lin_break_sync_baud_detect
